// File: verilog/pfs_supervisor.sv
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
// fault supervisor for a step-down point-of-load converter
module pfs_supervisor #(
  parameter int unsigned OT_DELAY = pfs_pkg::OT_DELAY_CYC, // overtemperature qualification cycles
  parameter int unsigned RETRY_PERIOD = pfs_pkg::RETRY_CYC // auto-retry period cycles
) (
  input wire logic clock, // 125 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb byte address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic [31:0] hrdata, // ahb read data
  output logic hresp, // ahb response
  input wire logic [15:0] voutMv, // measured output voltage, mV
  input wire logic [15:0] setpointMv, // output setpoint, mV
  input wire logic [15:0] ioutPermille, // output current, per-mille of rated
  input wire logic [7:0] tempC, // controller temperature, C
  input wire logic signed [15:0] trackErrMv, // tracking error, mV
  input wire logic rampUp, // output is ramping up
  output logic outputOn, // output allowed on
  output logic turnOffCmd, // one-cycle turn-off command
  output logic powerGoodOutput, // power good
  output logic overTempWarn, // overtemperature warning
  output logic irq // level interrupt
);

  pfs_reg_if regBus ();

  // configuration
  logic ctrlEnable; // output enable request
  logic ctrlTrackEn; // tracking protection enable
  logic restartPulse; // restart command strobe
  logic [pfs_pkg::NPROT-1:0] latchMode; // latching per protection
  logic [3:0] ocStep; // overcurrent step
  logic [1:0] ovStep; // overvoltage step
  logic [1:0] uvStep; // undervoltage step
  logic pgLowSel; // power good lower edge select
  logic [pfs_pkg::NEV-1:0] irqStatus; // sticky events
  logic [pfs_pkg::NEV-1:0] irqEnable; // interrupt enables

  // protection state
  pfs_pkg::pfs_state_t state; // protection state
  logic [31:0] retryCount; // retry wait counter
  logic [pfs_pkg::NPROT-1:0] cause; // last shutdown cause
  logic otBlock; // waiting for cool-down after overtemperature
  logic enablePrev; // previous enable for rising edge

  // comparisons
  logic [31:0] voutScaled; // vout times 100
  logic [31:0] ovLevel; // overvoltage level times 100
  logic ocCond; // overcurrent raw
  logic ovCond; // overvoltage raw
  logic uvCond; // undervoltage raw
  logic otCond; // overtemperature raw
  logic trkCond; // tracking raw
  logic warnCond; // warning raw
  logic inWindow; // vout inside power good window
  logic [pfs_pkg::NPROT-1:0] tripHit; // qualified trips
  logic warnHit; // qualified warning
  logic pgHit; // qualified window change
  logic tripNow; // trip taken this cycle
  logic [pfs_pkg::NEV-1:0] events; // interrupt events this cycle
  logic [pfs_pkg::NEV-1:0] irqClear; // clear strobe bits

  // value times percentage, wide enough for 16 by 8 bits
  function automatic logic [31:0] mulPct(input logic [15:0] v, input logic [7:0] p);
    mulPct = 32'(v) * 32'(p);
  endfunction

  // magnitude of a signed error
  function automatic logic [15:0] absMv(input logic signed [15:0] e);
    absMv = e[15] ? 16'(-e) : 16'(e);
  endfunction

  // overcurrent percent, clamped to the top step
  function automatic logic [7:0] ocPct(input logic [3:0] s);
    logic [3:0] c;
    c = (s > pfs_pkg::OC_STEP_MAX) ? pfs_pkg::OC_STEP_MAX : s;
    ocPct = 8'(pfs_pkg::OC_PCT_MIN + 8'(c) * pfs_pkg::OC_PCT_STEP);
  endfunction

  // overvoltage percent, clamped to the top step
  function automatic logic [7:0] ovPct(input logic [1:0] s);
    logic [1:0] c;
    c = (s > pfs_pkg::OV_STEP_MAX) ? pfs_pkg::OV_STEP_MAX : s;
    ovPct = 8'(pfs_pkg::OV_PCT_MIN + 8'(c) * pfs_pkg::OV_PCT_STEP);
  endfunction

  // bus slave
  pfs_ahb_slave ahbSlave (
    .clock(clock),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .bus(regBus)
  );

  // control register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrlEnable <= pfs_pkg::CTRL_ENABLE_RST;
      ctrlTrackEn <= pfs_pkg::CTRL_TRACK_EN_RST;
      restartPulse <= 1'b0;
    end else begin
      restartPulse <= regBus.wrEn && (regBus.wrAddr == pfs_pkg::REG_CTRL) &&
                      regBus.wdata[pfs_pkg::CTRL_RESTART];
      if (regBus.wrEn && (regBus.wrAddr == pfs_pkg::REG_CTRL)) begin
        ctrlEnable <= regBus.wdata[pfs_pkg::CTRL_ENABLE];
        ctrlTrackEn <= regBus.wdata[pfs_pkg::CTRL_TRACK_EN];
      end
    end
  end

  // latching selects and thresholds
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      latchMode <= pfs_pkg::LATCH_RST;
      ocStep <= pfs_pkg::TH_OC_RST;
      ovStep <= pfs_pkg::TH_OV_RST;
      uvStep <= pfs_pkg::TH_UV_RST;
      pgLowSel <= pfs_pkg::TH_PG_RST;
    end else if (regBus.wrEn) begin
      if (regBus.wrAddr == pfs_pkg::REG_LATCH) begin
        latchMode <= regBus.wdata[pfs_pkg::NPROT-1:0];
      end
      if (regBus.wrAddr == pfs_pkg::REG_THRESH) begin
        ocStep <= regBus.wdata[pfs_pkg::TH_OC_LSB +: 4];
        ovStep <= regBus.wdata[pfs_pkg::TH_OV_LSB +: 2];
        uvStep <= regBus.wdata[pfs_pkg::TH_UV_LSB +: 2];
        pgLowSel <= regBus.wdata[pfs_pkg::TH_PG_BIT];
      end
    end
  end

  // interrupt enable register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqEnable <= '0;
    end else if (regBus.wrEn && (regBus.wrAddr == pfs_pkg::REG_IRQ_ENABLE)) begin
      irqEnable <= regBus.wdata[pfs_pkg::NEV-1:0];
    end
  end

  // read multiplexer, unmapped and write-only offsets read zero
  always_comb begin
    regBus.rdata = 32'h00000000;
    case (regBus.rdAddr)
      pfs_pkg::REG_CTRL: begin
        regBus.rdata[pfs_pkg::CTRL_ENABLE] = ctrlEnable;
        regBus.rdata[pfs_pkg::CTRL_TRACK_EN] = ctrlTrackEn;
      end
      pfs_pkg::REG_LATCH: begin
        regBus.rdata[pfs_pkg::NPROT-1:0] = latchMode;
      end
      pfs_pkg::REG_THRESH: begin
        regBus.rdata[pfs_pkg::TH_OC_LSB +: 4] = ocStep;
        regBus.rdata[pfs_pkg::TH_OV_LSB +: 2] = ovStep;
        regBus.rdata[pfs_pkg::TH_UV_LSB +: 2] = uvStep;
        regBus.rdata[pfs_pkg::TH_PG_BIT] = pgLowSel;
      end
      pfs_pkg::REG_STATUS: begin
        regBus.rdata[pfs_pkg::ST_CAUSE_LSB +: pfs_pkg::NPROT] = cause;
        regBus.rdata[pfs_pkg::ST_WARN] = overTempWarn;
        regBus.rdata[pfs_pkg::ST_PG] = powerGoodOutput;
        regBus.rdata[pfs_pkg::ST_STATE_LSB +: 2] = state;
      end
      pfs_pkg::REG_IRQ_STATUS: begin
        regBus.rdata[pfs_pkg::NEV-1:0] = irqStatus;
      end
      pfs_pkg::REG_IRQ_ENABLE: begin
        regBus.rdata[pfs_pkg::NEV-1:0] = irqEnable;
      end
      default: begin
        regBus.rdata = 32'h00000000;
      end
    endcase
  end

  // raw fault conditions against the selected levels
  always_comb begin
    voutScaled = mulPct(voutMv, pfs_pkg::PCT_SCALE);
    ovLevel = mulPct(setpointMv, ovPct(ovStep));
    if (ovLevel < pfs_pkg::OV_FLOOR_SCALED) begin
      ovLevel = pfs_pkg::OV_FLOOR_SCALED;
    end
    // per-mille current against the percent level times ten
    ocCond = 32'(ioutPermille) > mulPct(16'(ocPct(ocStep)), pfs_pkg::PERMILLE_TO_PCT);
    ovCond = voutScaled > ovLevel;
    // undervoltage is masked while the output is off or ramping up, so a restart is not re-tripped
    uvCond = outputOn && !rampUp && (voutScaled <
             mulPct(setpointMv, 8'(pfs_pkg::UV_PCT_MIN + 8'(uvStep) * pfs_pkg::UV_PCT_STEP)));
    otCond = tempC >= pfs_pkg::OT_OFF_C;
    trkCond = ctrlTrackEn && rampUp && (absMv(trackErrMv) > pfs_pkg::TRACK_LIMIT_MV);
    warnCond = !overTempWarn && (tempC >= pfs_pkg::WARN_ON_C);
    inWindow = (voutScaled >= mulPct(setpointMv, pgLowSel ? pfs_pkg::PG_LOW_PCT1 : pfs_pkg::PG_LOW_PCT0)) &&
               (voutScaled <= mulPct(setpointMv, pfs_pkg::PG_HIGH_PCT));
  end

  // qualification delays
  pfs_delay_filter #(.LIMIT(pfs_pkg::FAULT_DELAY_CYC)) ocFilter (
    .clock(clock),
    .nrst(nrst),
    .cond(ocCond),
    .hit(tripHit[pfs_pkg::P_OC])
  );

  pfs_delay_filter #(.LIMIT(pfs_pkg::FAULT_DELAY_CYC)) ovFilter (
    .clock(clock),
    .nrst(nrst),
    .cond(ovCond),
    .hit(tripHit[pfs_pkg::P_OV])
  );

  pfs_delay_filter #(.LIMIT(pfs_pkg::FAULT_DELAY_CYC)) uvFilter (
    .clock(clock),
    .nrst(nrst),
    .cond(uvCond),
    .hit(tripHit[pfs_pkg::P_UV])
  );

  pfs_delay_filter #(.LIMIT(OT_DELAY)) otFilter (
    .clock(clock),
    .nrst(nrst),
    .cond(otCond),
    .hit(tripHit[pfs_pkg::P_OT])
  );

  pfs_delay_filter #(.LIMIT(pfs_pkg::FAULT_DELAY_CYC)) trkFilter (
    .clock(clock),
    .nrst(nrst),
    .cond(trkCond),
    .hit(tripHit[pfs_pkg::P_TRK])
  );

  pfs_delay_filter #(.LIMIT(pfs_pkg::FAULT_DELAY_CYC)) warnFilter (
    .clock(clock),
    .nrst(nrst),
    .cond(warnCond),
    .hit(warnHit)
  );

  pfs_delay_filter #(.LIMIT(pfs_pkg::FAULT_DELAY_CYC)) pgFilter (
    .clock(clock),
    .nrst(nrst),
    .cond(inWindow != powerGoodOutput),
    .hit(pgHit)
  );

  // a trip counts only while the output is on
  assign tripNow = (state == pfs_pkg::PFS_RUN) && ctrlEnable && (|tripHit);

  // protection state machine
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= pfs_pkg::PFS_RUN;
      retryCount <= 32'h00000000;
      cause <= '0;
    end else begin
      case (state)
        pfs_pkg::PFS_RUN: begin
          retryCount <= 32'h00000000;
          if (tripNow) begin
            cause <= tripHit;
            if (|(tripHit & latchMode)) begin
              state <= pfs_pkg::PFS_LATCHED;
            end else begin
              state <= pfs_pkg::PFS_RETRY;
            end
          end
        end
        pfs_pkg::PFS_RETRY: begin
          if (retryCount < RETRY_PERIOD - 1) begin
            retryCount <= retryCount + 32'h00000001;
          end else if (!otBlock) begin
            state <= pfs_pkg::PFS_RUN;
          end
        end
        pfs_pkg::PFS_LATCHED: begin
          // only an explicit restart or a fresh enable leaves this state
          if ((restartPulse || (ctrlEnable && !enablePrev)) && !otBlock) begin
            state <= pfs_pkg::PFS_RUN;
          end
        end
        default: begin
          state <= pfs_pkg::PFS_LATCHED;
        end
      endcase
    end
  end

  // overtemperature cool-down hold and enable edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      otBlock <= 1'b0;
      enablePrev <= pfs_pkg::CTRL_ENABLE_RST;
    end else begin
      enablePrev <= ctrlEnable;
      if (tripNow && tripHit[pfs_pkg::P_OT]) begin
        otBlock <= 1'b1;
      end else if (tempC <= pfs_pkg::OT_ON_C) begin
        otBlock <= 1'b0;
      end
    end
  end

  // converter outputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      outputOn <= 1'b0;
      turnOffCmd <= 1'b0;
    end else begin
      outputOn <= (state == pfs_pkg::PFS_RUN) && ctrlEnable && !tripNow;
      turnOffCmd <= tripNow;
    end
  end

  // warning with hysteresis and power good
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overTempWarn <= 1'b0;
      powerGoodOutput <= 1'b0;
    end else begin
      if (warnHit) begin
        overTempWarn <= 1'b1;
      end else if (tempC <= pfs_pkg::WARN_ON_C - pfs_pkg::WARN_HYST_C) begin
        overTempWarn <= 1'b0;
      end
      if (pgHit) begin
        powerGoodOutput <= inWindow;
      end
    end
  end

  // interrupt events
  always_comb begin
    events = '0;
    events[pfs_pkg::NPROT-1:0] = tripNow ? tripHit : '0;
    events[pfs_pkg::EV_WARN] = warnHit;
    events[pfs_pkg::EV_PG] = pgHit;
    irqClear = (regBus.wrEn && (regBus.wrAddr == pfs_pkg::REG_IRQ_CLEAR)) ? regBus.wdata[pfs_pkg::NEV-1:0] : '0;
  end

  // sticky status, a new event wins over a clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | events;
      irq <= |(irqStatus & irqEnable);
    end
  end

endmodule

// File: verilog/pfs_pkg.sv
package pfs_pkg;

  // clock and timing
  localparam int unsigned CLOCK_NS = 8; // 125 MHz clock period
  localparam int unsigned FAULT_DELAY_NS = 6000; // nominal 6 us qualification
  localparam int unsigned FAULT_DELAY_CYC = FAULT_DELAY_NS / CLOCK_NS; // 750 cycles
  localparam int unsigned OT_DELAY_MS = 2; // overtemperature qualification
  localparam int unsigned OT_DELAY_CYC = (OT_DELAY_MS * 1000000) / CLOCK_NS; // 250000 cycles
  localparam int unsigned RETRY_MS = 130; // auto-retry period
  localparam int unsigned RETRY_CYC = (RETRY_MS * 1000000) / CLOCK_NS; // 16250000 cycles

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00; // enable, restart, tracking enable
  localparam logic [7:0] REG_LATCH = 8'h04; // latching select per protection
  localparam logic [7:0] REG_THRESH = 8'h08; // threshold step selects
  localparam logic [7:0] REG_STATUS = 8'h0c; // live state, read only
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10; // sticky events, read only
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h14; // write one to clear, write only
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h18; // interrupt enables

  // control bits
  localparam int unsigned CTRL_ENABLE = 0; // output enable request
  localparam int unsigned CTRL_RESTART = 1; // write one: restart after latched trip
  localparam int unsigned CTRL_TRACK_EN = 2; // tracking protection enable
  localparam logic CTRL_ENABLE_RST = 1'b1; // output on by default
  localparam logic CTRL_TRACK_EN_RST = 1'b0; // tracking off by default

  // protection index, shared by latch, cause and event bits
  localparam int unsigned NPROT = 5; // number of protections
  localparam int unsigned P_OC = 0; // overcurrent
  localparam int unsigned P_OV = 1; // overvoltage
  localparam int unsigned P_UV = 2; // undervoltage
  localparam int unsigned P_OT = 3; // overtemperature
  localparam int unsigned P_TRK = 4; // tracking
  localparam logic [4:0] LATCH_RST = 5'h00; // all non-latching by default
  localparam int unsigned EV_WARN = 5; // warning raised event
  localparam int unsigned EV_PG = 6; // power good change event
  localparam int unsigned NEV = 7; // number of interrupt events

  // threshold field layout and reset values
  localparam int unsigned TH_OC_LSB = 0; // [3:0] overcurrent step
  localparam int unsigned TH_OV_LSB = 4; // [5:4] overvoltage step
  localparam int unsigned TH_UV_LSB = 8; // [9:8] undervoltage step
  localparam int unsigned TH_PG_BIT = 12; // power good lower edge select
  localparam logic [3:0] TH_OC_RST = 4'ha; // 140 percent
  localparam logic [1:0] TH_OV_RST = 2'h2; // 130 percent
  localparam logic [1:0] TH_UV_RST = 2'h0; // 75 percent
  localparam logic TH_PG_RST = 1'b0; // 90 percent

  // status field layout
  localparam int unsigned ST_CAUSE_LSB = 0; // [4:0] last shutdown cause
  localparam int unsigned ST_WARN = 5; // overtemperature warning
  localparam int unsigned ST_PG = 6; // power good
  localparam int unsigned ST_STATE_LSB = 8; // [9:8] protection state

  // percentages and limits
  localparam logic [7:0] OC_PCT_MIN = 8'h28; // 40 percent
  localparam logic [7:0] OC_PCT_STEP = 8'h0a; // 10 percent
  localparam logic [3:0] OC_STEP_MAX = 4'ha; // 11 steps, 0..10
  localparam logic [7:0] OV_PCT_MIN = 8'h6e; // 110 percent
  localparam logic [7:0] OV_PCT_STEP = 8'h0a; // 10 percent
  localparam logic [1:0] OV_STEP_MAX = 2'h2; // 110, 120, 130
  localparam logic [7:0] UV_PCT_MIN = 8'h4b; // 75 percent
  localparam logic [7:0] UV_PCT_STEP = 8'h05; // 5 percent
  localparam logic [7:0] PG_LOW_PCT0 = 8'h5a; // 90 percent
  localparam logic [7:0] PG_LOW_PCT1 = 8'h5f; // 95 percent
  localparam logic [7:0] PG_HIGH_PCT = 8'h6e; // 110 percent
  localparam logic [7:0] PCT_SCALE = 8'h64; // 100 percent
  localparam logic [7:0] PERMILLE_TO_PCT = 8'h0a; // per-mille over percent
  localparam logic [31:0] OV_FLOOR_SCALED = 32'h000186a0; // 1000 mV times 100
  localparam logic [15:0] TRACK_LIMIT_MV = 16'h00fa; // 250 mV
  localparam logic [7:0] OT_OFF_C = 8'h78; // 120 C
  localparam logic [7:0] OT_ON_C = 8'h6e; // 110 C
  localparam logic [7:0] WARN_ON_C = 8'h78; // 120 C
  localparam logic [7:0] WARN_HYST_C = 8'h03; // 3 C

  // protection state
  typedef enum logic [1:0] {
    PFS_RUN,
    PFS_RETRY,
    PFS_LATCHED
  } pfs_state_t;

endpackage

// File: verilog/pfs_reg_if.sv
`timescale 1ns/10ps
// register access strobes between bus slave and register file
interface pfs_reg_if;
  logic wrEn; // write strobe, one cycle
  logic [7:0] wrAddr; // write byte offset
  logic [31:0] wdata; // write data
  logic rdEn; // read strobe at address phase
  logic [7:0] rdAddr; // read byte offset
  logic [31:0] rdata; // read data, combinational

  modport slave (output wrEn, output wrAddr, output wdata, output rdEn, output rdAddr, input rdata);
  modport regs (input wrEn, input wrAddr, input wdata, input rdEn, input rdAddr, output rdata);
endinterface

// File: verilog/pfs_delay_filter.sv
`timescale 1ns/10ps
// qualifies a condition: hit goes high once cond has held LIMIT cycles
module pfs_delay_filter #(
  parameter int unsigned LIMIT = 750
) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic cond, // raw condition
  output logic hit // condition held long enough
);

  logic [31:0] count; // cycles cond has held, saturating

  // count while cond holds, restart when it drops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h00000000;
    end else if (!cond) begin
      count <= 32'h00000000;
    end else if (count != LIMIT) begin
      count <= count + 32'h00000001;
    end
  end

  assign hit = cond && (count == LIMIT); // hold after saturation

endmodule

// File: verilog/pfs_ahb_slave.sv
`timescale 1ns/10ps
// ahb-lite slave, zero wait states, always okay
module pfs_ahb_slave (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // response, okay
  pfs_reg_if.slave bus // register strobes
);

  logic wrPend; // write data phase pending
  logic [7:0] wrAddrQ; // captured write offset
  logic take; // valid address phase

  // nonseq or seq, selected, with previous transfer done
  assign take = hsel && htrans[1] && hready && (hsize == 3'h2);

  // capture write address for the data phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPend <= 1'b0;
      wrAddrQ <= 8'h00;
    end else begin
      wrPend <= take && hwrite;
      if (take && hwrite) begin
        wrAddrQ <= haddr[7:0];
      end
    end
  end

  // read data registered at the address phase edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= bus.rdata;
    end
  end

  assign bus.wrEn = wrPend;
  assign bus.wrAddr = wrAddrQ;
  assign bus.wdata = hwdata;
  assign bus.rdEn = take && !hwrite;
  assign bus.rdAddr = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

// File: testbench/pfs_checker.sv
`timescale 1ns/10ps
// watches supervisor ports for trip, warning and power good timing
module pfs_checker #(parameter int unsigned OT_DELAY = 20, parameter int unsigned RETRY_PERIOD = 40) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [15:0] voutMv, // output voltage, mV
  input wire logic [15:0] setpointMv, // setpoint, mV
  input wire logic [7:0] tempC, // temperature, C
  input wire logic outputOn, // output allowed on
  input wire logic turnOffCmd, // trip pulse
  input wire logic powerGoodOutput, // power good
  input wire logic overTempWarn // temperature warning
);
  logic [9:0] hot, high, off; // run lengths, saturating
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // hot and above-window run lengths, cycles since last trip
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hot <= 10'h000;
      high <= 10'h000;
      off <= 10'h3ff;
    end else begin
      hot <= (tempC >= 8'h78) ? hot + {9'h000, hot != 10'h3ff} : 10'h000;
      high <= (32'(voutMv) * 32'h64 > 32'(setpointMv) * 32'h6e) ? high + {9'h000, high != 10'h3ff} : 10'h000;
      off <= turnOffCmd ? 10'h000 : off + {9'h000, off != 10'h3ff};
    end
  end
  // output already off with the pulse, pulse lasts one cycle
  sequence s_off;
    !outputOn ##1 !turnOffCmd ##1 !outputOn;
  endsequence
  a_trip_pulse_once: assert property ($rose(turnOffCmd) |-> s_off) else $error("trip pulse wrong");
  a_trip_from_on: assert property ($rose(turnOffCmd) |-> $past(outputOn)) else $error("trip while off");
  a_retry_wait: assert property ($rose(outputOn) |-> off >= RETRY_PERIOD - 1) else $error("early turn-on");
  a_ot_trip_delay: assert property (hot == OT_DELAY + 3 |-> !outputOn) else $error("no thermal trip");
  a_warn_late: assert property (hot == 10'h2f1 |-> overTempWarn) else $error("warning late");
  a_warn_early: assert property ($rose(overTempWarn) |-> hot >= 10'h2ee) else $error("warning early");
  a_warn_hold: assert property (overTempWarn && tempC > 8'h75 |=> overTempWarn) else $error("warning lost");
  a_warn_clear: assert property (tempC <= 8'h75 |=> !overTempWarn) else $error("warning stuck");
  a_pg_above: assert property (high == 10'h2f1 |-> !powerGoodOutput) else $error("good when high");
  a_pg_rise: assert property ($rose(powerGoodOutput) |-> high == 10'h000) else $error("good rose high");
endmodule
bind pfs_supervisor pfs_checker #(.OT_DELAY(OT_DELAY), .RETRY_PERIOD(RETRY_PERIOD)) u_chk (.clock(clock),
  .nrst(nrst), .voutMv(voutMv), .setpointMv(setpointMv), .tempC(tempC), .outputOn(outputOn),
  .turnOffCmd(turnOffCmd), .powerGoodOutput(powerGoodOutput), .overTempWarn(overTempWarn));

// File: testbench/pfs_plant.sv
`timescale 1ns/10ps
// power stage: output slews toward target while enabled
module pfs_plant (
  input wire logic clock, // system clock
  input wire logic outputOn, // enable from supervisor
  input wire logic [15:0] target, // steady level, mV
  output logic [15:0] voutMv, // measured output, mV
  output logic rampUp // high while rising
);
  // discharge when off, else step 200 mV toward target
  always_ff @(posedge clock) begin
    if (!outputOn) begin
      voutMv <= 16'h0000;
    end else begin
      voutMv <= (voutMv + 16'h00c8 < target) ? voutMv + 16'h00c8 : target;
    end
  end
  assign rampUp = outputOn && (voutMv < target);
endmodule

// File: testbench/tb.sv
`timescale 1ns/10ps
// bench: reset values, trips, retry, latch, warning, interrupt
module tb;
  logic clock, nrst, hwrite, hreadyout, hresp, rampUp, outputOn, turnOffCmd, powerGoodOutput, overTempWarn, irq;
  logic [1:0] htrans; // transfer type
  logic [31:0] haddr, hwdata, hrdata, rd, seed; // bus and random state
  logic [15:0] voutMv, setpointMv, target, iout, sp; // plant levels
  logic [7:0] tempC; // temperature
  int errCount, samplesChecked, n; // counters
  pfs_supervisor #(.OT_DELAY(20), .RETRY_PERIOD(40)) u_dut (.clock(clock), .nrst(nrst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .voutMv(voutMv), .setpointMv(setpointMv), .ioutPermille(iout), .tempC(tempC),
    .trackErrMv(16'sh0000), .rampUp(rampUp), .outputOn(outputOn), .turnOffCmd(turnOffCmd),
    .powerGoodOutput(powerGoodOutput), .overTempWarn(overTempWarn), .irq(irq));
  pfs_plant u_plant (.clock(clock), .outputOn(outputOn), .target(target), .voutMv(voutMv), .rampUp(rampUp));
  // xorshift random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // overvoltage level in mV: 130 percent of setpoint, floored at 1 V
  function automatic logic [15:0] ovLevel(input logic [15:0] s);
    return (s * 16'h000d / 16'h000a > 16'h03e8) ? s * 16'h000d / 16'h000a : 16'h03e8;
  endfunction
  // compare and count
  task automatic chk(input logic [31:0] exp, input logic [31:0] act);
    samplesChecked++;
    if (exp !== act) begin
      errCount++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask
  // one single-word transfer, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // bounded wait for a flag: 0 trip, 1 output on, 2 warning
  task automatic waitHi(input int k);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (((k == 0) ? turnOffCmd : (k == 1) ? outputOn : overTempWarn) !== 1'b1 && n < 3000);
    if (n >= 3000) errCount++;
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checked %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // watchdog
  initial begin
    #400000 errCount++;
    summarize();
  end
  initial begin
    {nrst, hwrite, htrans, haddr, hwdata, iout, tempC} = '0;
    {setpointMv, target, seed, errCount, samplesChecked} = {16'h03e8, 16'h03e8, 32'h32, 64'h0};
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    bus(1'b0, pfs_pkg::REG_CTRL, 0);
    chk(32'h1, rd);
    bus(1'b0, pfs_pkg::REG_THRESH, 0);
    chk({19'h0, pfs_pkg::TH_PG_RST, 2'h0, pfs_pkg::TH_UV_RST, 2'h0, pfs_pkg::TH_OV_RST, pfs_pkg::TH_OC_RST}, rd);
    repeat (800) @(posedge clock);
    chk(32'h1, {30'h0, hresp, powerGoodOutput});
    $display("reset and window test done");
    @(posedge clock);
    sp = 16'h0258 + 16'(xs() % 100);
    setpointMv <= sp;
    target <= ovLevel(sp) - 16'h000a;
    repeat (1000) @(posedge clock);
    chk(32'h1, {31'h0, outputOn});
    target <= ovLevel(sp) + 16'h0001 + 16'(xs() % 64);
    waitHi(0);
    chk(32'h1, 32'(n >= 751 && n <= 755));
    {setpointMv, target} <= {16'h03e8, 16'h03e8};
    waitHi(1);
    chk(32'h1, 32'(n >= 38 && n <= 43));
    $display("overvoltage test done");
    bus(1'b1, pfs_pkg::REG_THRESH, 32'h0000032a);
    bus(1'b1, pfs_pkg::REG_LATCH, 32'h1 << pfs_pkg::P_UV);
    target <= 16'h0370;
    waitHi(0);
    chk(32'h1, 32'(n >= 751 && n <= 755));
    target <= 16'h03e8;
    repeat (200) @(posedge clock);
    bus(1'b0, pfs_pkg::REG_STATUS, 0);
    chk(32'hb, {rd[9:8], rd[9:8] == 2'h2 && !outputOn, rd[pfs_pkg::P_UV]});
    bus(1'b1, pfs_pkg::REG_CTRL, 32'h3);
    waitHi(1);
    chk(32'h1, 32'(n < 10));
    $display("latched undervoltage test done");
    bus(1'b1, pfs_pkg::REG_THRESH, 32'h000000a0 | (xs() % 11));
    bus(1'b0, pfs_pkg::REG_THRESH, 0);
    iout <= 16'h0190 + 16'h0064 * rd[3:0];
    repeat (800) @(posedge clock);
    chk(32'h1, {31'h0, outputOn});
    iout <= 16'h0191 + 16'h0064 * rd[3:0];
    waitHi(0);
    chk(32'h1, 32'(n >= 749 && n <= 754));
    iout <= 16'h0000;
    waitHi(1);
    $display("overcurrent test done");
    bus(1'b1, pfs_pkg::REG_IRQ_ENABLE, 32'h1 << pfs_pkg::EV_WARN);
    tempC <= 8'h78 + 8'(xs() % 8);
    waitHi(0);
    chk(32'h1, 32'(n >= 20 && n <= 24));
    waitHi(2);
    repeat (2) @(posedge clock);
    chk(32'h1, {31'h0, irq});
    tempC <= 8'h73;
    repeat (60) @(posedge clock);
    chk(32'h0, {31'h0, outputOn | overTempWarn});
    bus(1'b1, pfs_pkg::REG_IRQ_CLEAR, 32'h7f);
    repeat (2) @(posedge clock);
    chk(32'h0, {31'h0, irq});
    tempC <= 8'h64;
    waitHi(1);
    chk(32'h1, 32'(n >= 3 && n <= 5));
    $display("temperature test done");
    summarize();
  end
endmodule
